/* rtl/fbi_host.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (RL1) Reads: chip select, output enable low, write high
// (RL2) After reset, reads need no command
// (RL3) Banks read array until command written
// (RL4) Eight-word page: upper bits page, low index
// (RL5) New page or select toggle: full access
// (RL6) Reads allowed while other bank busy
// (RL7) Bank decoded from top three address bits
// (RL8) Writes: write enable, select low, output high
// (RL9) Short program mode takes two writes
// (RL10) Sector, multi-sector or chip erase possible
// (RL11) High voltage: short program, sectors unprotected
// (RL12) High voltage only while accelerating, else high
// (RL13) Autoselect reads use normal read timing
// (RL14) Standby outputs float regardless of output enable
// (RL15) Standby when select, reset high; full access
// (RL16) Deselect does not stop embedded operations
// (RL17) Auto sleep after stable address
// (RL18) Sleep keeps data; new address full access
// (RL19) Reset pulse aborts, floats outputs, array read
// (RL20) Host reissues operations cut by reset
// (RL21) Busy held low until reset recovery done
// (RL22) Wait reset-high-to-read before first read
// (RL23) Output enable high floats data pins
// (RL24) Protect pin low keeps boot sectors locked
// (RL25) Busy low while any embedded operation runs
module fbi_host
  import fbi_pkg::*;
#(
  parameter int RESET_PULSE_CYCLES = RESET_PULSE_CYC,  // Reset pulse length
  parameter int RESET_READY_CYCLES = RESET_READY_CYC   // Reset recovery bound, unused: the recovery wait has no limit
) (
  input  wire logic              clk_sys,        // System clock
  input  wire logic              arst_n,         // Async reset, active low
  // User side
  input  wire logic              req_valid,      // Access request
  input  wire logic              req_write,      // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] req_addr,       // Word address
  input  wire logic [DATA_W-1:0] req_wdata,      // Write data
  input  wire logic              req_accel,      // Apply high voltage
  input  wire logic              req_reset,      // Pulse the device reset
  output logic                   req_ready,      // Request taken
  output logic                   rsp_valid,      // Access complete pulse
  output logic [DATA_W-1:0]      rsp_rdata,      // Read data
  output logic [1:0]             rsp_bank,       // Bank of the access
  output logic                   dev_busy,       // Device busy level
  // Device pins
  output logic                   chip_select_n,  // Chip select
  output logic                   output_en_n,    // Output enable
  output logic                   write_en_n,     // Write enable
  output logic                   dev_reset_n,    // Hardware reset
  output logic [ADDR_W-1:0]      addr_pins,      // Address
  input  wire logic [DATA_W-1:0] data_pins_i,    // Data in
  output logic [DATA_W-1:0]      data_pins_o,    // Data out
  output logic                   data_pins_oe,   // High while driving
  output logic                   accel_hv_en,    // High voltage on protect pin
  input  wire logic              ready_busy_n    // Busy, low active
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Bank from the top three address bits
  function automatic logic [1:0] bank_of(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = a[ADDR_W-1:BANK_LSB];
    if (s == 3'h0)      return BANK_A;  // RL7
    else if (s == 3'h7) return BANK_D;
    else if (s[2])      return BANK_C;
    else                return BANK_B;
  endfunction

  // Same page when the page address bits agree
  function automatic logic same_page(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
    return a[ADDR_W-1:PAGE_LSB] == b[ADDR_W-1:PAGE_LSB];  // RL4
  endfunction

  localparam int CNT_W = 24;  // Wide enough for the reset pulse count

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fbi_state_t              st_q, st_d;          // Controller state
  logic [CNT_W-1:0]        cnt_q, cnt_d;        // Wait counter
  logic [ADDR_W-1:0]       addr_q, addr_d;      // Address on the pins
  logic [DATA_W-1:0]       wdat_q, wdat_d;      // Write data held
  logic [DATA_W-1:0]       rdat_q, rdat_d;      // Captured read data
  logic                    cs_n_q, cs_n_d;      // Chip select
  logic                    oe_n_q, oe_n_d;      // Output enable
  logic                    we_n_q, we_n_d;      // Write enable
  logic                    rst_n_q, rst_n_d;    // Device reset
  logic                    drv_q, drv_d;        // Data drive enable
  logic                    pg_ok_q, pg_ok_d;    // Open page is valid
  logic                    vld_q, vld_d;        // Response pulse
  logic                    acc_q, acc_d;        // High voltage request
  logic [7:0]              age_q, age_d;        // Check helper: cycles the page stood selected

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rdat_d  = rdat_q;
    cs_n_d  = cs_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    rst_n_d = rst_n_q;
    drv_d   = drv_q;
    pg_ok_d = pg_ok_q;
    vld_d   = 1'b0;
    // High voltage only on request, while not resetting; RL12 RL11
    acc_d   = req_accel && (st_q != FBI_RST_PULSE);
    unique case (st_q)
      FBI_RST_PULSE: begin
        // Hold reset low for the pulse width; outputs float
        rst_n_d = 1'b0;  // RL19
        cs_n_d  = 1'b1;
        oe_n_d  = 1'b1;
        we_n_d  = 1'b1;
        drv_d   = 1'b0;
        pg_ok_d = 1'b0;
        if (cnt_q == '0) begin
          rst_n_d = 1'b1;
          st_d    = FBI_RST_WAIT;
          cnt_d   = CNT_W'(RESET_TO_READ_CYC);
        end
      end
      FBI_RST_WAIT: begin
        // Wait reset-to-read, and for busy to clear, with no time limit
        if (cnt_q == '0 && ready_busy_n) begin  // RL22 RL21
          st_d = FBI_IDLE;
        end
      end
      FBI_IDLE: begin
        if (req_reset) begin
          st_d  = FBI_RST_PULSE;
          cnt_d = CNT_W'(RESET_PULSE_CYCLES);  // Pin falls a cycle later, full width
        end else if (req_valid && req_write) begin
          // Command write: select and write low, output high; RL8 RL3 RL9 RL10
          addr_d  = req_addr;
          wdat_d  = req_wdata;
          cs_n_d  = 1'b0;
          oe_n_d  = 1'b1;
          we_n_d  = 1'b0;
          drv_d   = 1'b1;
          pg_ok_d = 1'b0;
          cnt_d   = CNT_W'(WRITE_PULSE_CYC - 1);
          st_d    = FBI_WR_LOW;
        end else if (req_valid) begin
          // Read: select and output low, write high; RL1 RL2 RL13
          // Page hit only while selected on the same page; RL5 RL15 RL18
          if (pg_ok_q && !cs_n_q && same_page(req_addr, addr_q))
            cnt_d = CNT_W'(PAGE_ACCESS_CYC - 1);
          else
            cnt_d = CNT_W'(((ADDR_ACCESS_CYC > CS_ACCESS_CYC) ?
                            ADDR_ACCESS_CYC : CS_ACCESS_CYC) - 1);
          addr_d = req_addr;
          cs_n_d = 1'b0;
          oe_n_d = 1'b0;
          we_n_d = 1'b1;
          drv_d  = 1'b0;
          st_d   = FBI_RD_WAIT;
        end else begin
          // Nothing queued: drop to standby, page closes; RL15 RL14
          cs_n_d  = 1'b1;
          oe_n_d  = 1'b1;
          pg_ok_d = 1'b0;
        end
      end
      FBI_RD_WAIT: begin
        if (cnt_q == '0) begin
          rdat_d  = data_pins_i;
          vld_d   = 1'b1;
          pg_ok_d = 1'b1;
          st_d    = FBI_RD_DONE;
        end
      end
      FBI_RD_DONE: begin
        // Keep selected one cycle so a back-to-back page read hits
        st_d = FBI_IDLE;
      end
      FBI_WR_LOW: begin
        if (cnt_q == '0) begin
          we_n_d = 1'b1;  // Data latched on rising write enable
          cnt_d  = CNT_W'(WRITE_RECOV_CYC - 1);
          st_d   = FBI_WR_HIGH;
        end
      end
      FBI_WR_HIGH: begin
        if (cnt_q == '0) begin
          drv_d  = 1'b0;
          cs_n_d = 1'b1;
          vld_d  = 1'b1;
          st_d   = FBI_IDLE;
        end
      end
      default: st_d = FBI_IDLE;
    endcase
    age_d = (cs_n_q || !same_page(addr_d, addr_q)) ? 8'h00 :
            (age_q == 8'hff) ? age_q : age_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= FBI_RST_PULSE;
      cnt_q   <= CNT_W'(RESET_PULSE_CYCLES - 1);
      addr_q  <= '0;
      wdat_q  <= '0;
      rdat_q  <= '0;
      cs_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      rst_n_q <= 1'b0;
      drv_q   <= 1'b0;
      pg_ok_q <= 1'b0;
      vld_q   <= 1'b0;
      acc_q   <= 1'b0;
      age_q   <= 8'h00;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      cs_n_q  <= cs_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      rst_n_q <= rst_n_d;
      drv_q   <= drv_d;
      pg_ok_q <= pg_ok_d;
      vld_q   <= vld_d;
      acc_q   <= acc_d;
      age_q   <= age_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready     = (st_q == FBI_IDLE) && !req_reset;
  assign rsp_valid     = vld_q;
  assign rsp_rdata     = rdat_q;
  assign rsp_bank      = bank_of(addr_q);  // RL6
  assign dev_busy      = !ready_busy_n;    // RL25 RL16
  assign chip_select_n = cs_n_q;
  assign output_en_n   = oe_n_q;
  assign write_en_n    = we_n_q;
  assign dev_reset_n   = rst_n_q;
  assign addr_pins     = addr_q;           // RL17 RL18
  assign data_pins_o   = wdat_q;
  assign data_pins_oe  = drv_q;
  assign accel_hv_en   = acc_q;            // RL11 RL24

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_read_pins: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL1
    (!oe_n_q) |-> (!cs_n_q && we_n_q))
    else $error("read strobes wrong");
  a_write_pins: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL8
    (!we_n_q) |-> (!cs_n_q && oe_n_q && drv_q))
    else $error("write strobes wrong");
  a_no_contend: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL23
    drv_q |-> oe_n_q)
    else $error("host drives while device may");
  a_reset_float: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL19
    (!rst_n_q) |-> (cs_n_q && oe_n_q && we_n_q && !drv_q && !acc_q))
    else $error("strobes active during reset");
  a_reset_width: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL19
    $fell(rst_n_q) |-> (!rst_n_q) [*8])
    else $error("reset pulse too short");
  a_reset_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL22
    $fell(oe_n_q) |-> $past(rst_n_q, RESET_TO_READ_CYC))
    else $error("read too soon after reset");
  a_read_time: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL5
    (rsp_valid && !oe_n_q) |-> (age_q >= ADDR_ACCESS_CYC))
    else $error("full access cut short");
  a_page_time: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL4
    (st_q == FBI_IDLE && req_valid && !req_write && !req_reset &&
     pg_ok_q && !cs_n_q && same_page(req_addr, addr_q))
    |=> ##7 rsp_valid)
    else $error("page access wrong length");
  a_bank_map: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL7
    (addr_q[ADDR_W-1:BANK_LSB] == 3'h5) |-> (rsp_bank == BANK_C))
    else $error("bank decode wrong");
  a_standby: assert property (@(posedge clk_sys) disable iff (!arst_n) // RL15
    (cs_n_q && rst_n_q) |-> (!drv_q && oe_n_q && we_n_q))
    else $error("standby with strobes");
endmodule

`default_nettype wire

/* rtl/fbi_pkg.sv */
package fbi_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W        = 22;       // Word address width
  localparam int DATA_W        = 16;       // Data pins width
  localparam int PAGE_LSB      = 3;        // Lowest page address bit
  localparam int BANK_LSB      = 19;       // Lowest bank select bit
  localparam int CLK_PERIOD_PS = 4000;     // System clock period

  // ----------------------------------------------------------------
  // Timing figures in picoseconds, plain defaults
  // ----------------------------------------------------------------
  localparam int ADDR_ACCESS_PS   = 70000;  // Address access time
  localparam int CS_ACCESS_PS     = 70000;  // Chip select access time
  localparam int PAGE_ACCESS_PS   = 25000;  // Page access time
  localparam int WRITE_PULSE_PS   = 35000;  // Write enable low time
  localparam int WRITE_RECOV_PS   = 20000;  // Write enable high recovery
  localparam int RESET_PULSE_PS   = 500000; // Reset pulse width
  localparam int RESET_TO_READ_PS = 50000;  // Reset high to read time
  localparam int RESET_READY_PS   = 20000000; // Reset recovery time

  // Least times round up to whole cycles
  function automatic int cyc_up(input int ps);
    return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction

  localparam int ADDR_ACCESS_CYC   = cyc_up(ADDR_ACCESS_PS);
  localparam int CS_ACCESS_CYC     = cyc_up(CS_ACCESS_PS);
  localparam int PAGE_ACCESS_CYC   = cyc_up(PAGE_ACCESS_PS);
  localparam int WRITE_PULSE_CYC   = cyc_up(WRITE_PULSE_PS);
  localparam int WRITE_RECOV_CYC   = cyc_up(WRITE_RECOV_PS);
  localparam int RESET_PULSE_CYC   = cyc_up(RESET_PULSE_PS);
  localparam int RESET_TO_READ_CYC = cyc_up(RESET_TO_READ_PS);
  localparam int RESET_READY_CYC   = cyc_up(RESET_READY_PS);

  // ----------------------------------------------------------------
  // Bank codes
  // ----------------------------------------------------------------
  localparam logic [1:0] BANK_A = 2'h0;
  localparam logic [1:0] BANK_B = 2'h1;
  localparam logic [1:0] BANK_C = 2'h2;
  localparam logic [1:0] BANK_D = 2'h3;

  // Controller states
  typedef enum logic [3:0] {
    FBI_RST_PULSE, FBI_RST_WAIT, FBI_IDLE, FBI_RD_WAIT, FBI_RD_DONE,
    FBI_WR_LOW, FBI_WR_HIGH
  } fbi_state_t;
endpackage

/* verification/fbi_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Flash device seen from its pins, behavioural
// ----------------------------------------------------------------
module fbi_dev_model
  import fbi_pkg::*;
#(
  parameter int ACC_CYC  = ADDR_ACCESS_CYC - 4,  // Full access, margin for pin registers
  parameter int PG_CYC   = PAGE_ACCESS_CYC - 4,  // In-page access
  parameter int BUSY_CYC = 200,                  // Embedded erase length
  parameter int RCV_CYC  = 60                    // Recovery when reset cuts an erase
) (
  input  wire logic              clk_sys,        // Sampling clock
  input  wire logic              chip_select_n,  // Select, active low
  input  wire logic              output_en_n,    // Output gate, active low
  input  wire logic              write_en_n,     // Write strobe, active low
  input  wire logic              dev_reset_n,    // Hardware reset
  input  wire logic [ADDR_W-1:0] addr_pins,      // Word address
  input  wire logic [DATA_W-1:0] data_pins_o,    // Host data
  input  wire logic              data_pins_oe,   // Host drives data
  output logic [DATA_W-1:0]      data_pins_i,    // Device data
  output logic                   ready_busy_n    // Low while busy
);
  logic [ADDR_W-1:0] last_q = '0;                // Address seen last edge
  logic [DATA_W-1:0] drv_q  = '0;                // Value on the data pins
  logic              hit_q  = 1'b0;              // Open page access
  logic              ok_q   = 1'b0;              // Data was valid last edge
  int                cnt_q  = 0;                 // Edges with stable address
  int                busy_q = 0;                 // Embedded operation left
  logic              valid;                      // Word settled

  // Array content is a fixed pattern of the address
  function automatic logic [DATA_W-1:0] arr_word(input logic [ADDR_W-1:0] a);
    return a[15:0] ^ {a[21:16], 10'h2a5};
  endfunction

  // Data settles only after the access time for this kind of access
  assign valid = (addr_pins == last_q) && (cnt_q >= (hit_q ? PG_CYC : ACC_CYC));
  assign ready_busy_n = (busy_q == 0);
  assign data_pins_i = drv_q;

  // ----------------------------------------------------------------
  // Access timing, busy and output drive
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!dev_reset_n) begin
      // Abort, close pages, back to array read; busy kept through recovery
      cnt_q <= 0;
      hit_q <= 1'b0;
      busy_q <= (busy_q > 0) ? RCV_CYC : 0;
    end else begin
      // Erase runs on even when deselected
      if (busy_q > 0) busy_q <= busy_q - 1;
      if (chip_select_n) begin
        cnt_q <= 0;
        hit_q <= 1'b0;
      end else if (addr_pins != last_q) begin
        cnt_q <= 0;
        hit_q <= ok_q && (addr_pins[21:3] == last_q[21:3]);
      end else begin
        cnt_q <= cnt_q + 1;
      end
      // Erase command word starts an embedded operation
      if (!chip_select_n && !write_en_n && data_pins_oe && data_pins_o == 16'h0030) begin
        busy_q <= BUSY_CYC;
      end
    end
    last_q <= addr_pins;
    ok_q <= valid;
    // Array reads served in any bank, busy or not; no pull, so a floating bus toggles
    if (valid && !output_en_n && !chip_select_n && dev_reset_n) begin
      drv_q <= arr_word(addr_pins);
    end else begin
      drv_q <= ~drv_q;
    end
  end
endmodule

`default_nettype wire

/* verification/fbi_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module fbi_host_tb;
  import fbi_pkg::*;
  localparam int RST_CYC = 8;  // Short reset pulse keeps the run brief
  typedef struct {logic w; logic hit; logic [ADDR_W-1:0] a; int t;} fbi_exp_t;
  logic clk_sys = 0, arst_n = 0, req_valid = 0, req_write = 0, req_accel = 0, req_reset = 0;
  logic [ADDR_W-1:0] req_addr = '0, addr_pins, a;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_pins_i, data_pins_o;
  logic req_ready, rsp_valid, dev_busy, chip_select_n, output_en_n, write_en_n, dev_reset_n;
  logic data_pins_oe, accel_hv_en, ready_busy_n;
  logic [1:0] rsp_bank;
  logic [31:0] seed = 32'h0752;  // Fixed seed, repeatable run
  int miscompares = 0, total_checks = 0, cyc = 0, rlow = 0, since = 0;
  fbi_exp_t exp_q[$], e;         // Responses still owed

  always #2 clk_sys = ~clk_sys;

  fbi_host #(.RESET_PULSE_CYCLES(RST_CYC), .RESET_READY_CYCLES(16)) u_dut (.clk_sys, .arst_n,
    .req_valid, .req_write, .req_addr, .req_wdata, .req_accel, .req_reset, .req_ready,
    .rsp_valid, .rsp_rdata, .rsp_bank, .dev_busy, .chip_select_n, .output_en_n, .write_en_n,
    .dev_reset_n, .addr_pins, .data_pins_i, .data_pins_o, .data_pins_oe, .accel_hv_en,
    .ready_busy_n);
  fbi_dev_model u_dev (.clk_sys, .chip_select_n, .output_en_n, .write_en_n, .dev_reset_n,
    .addr_pins, .data_pins_o, .data_pins_oe, .data_pins_i, .ready_busy_n);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [DATA_W-1:0] exp_word(input logic [ADDR_W-1:0] x);
    return x[15:0] ^ {x[21:16], 10'h2a5};
  endfunction
  function automatic logic [1:0] exp_bank(input logic [2:0] c);
    return (c == 3'h0) ? BANK_A : (c == 3'h7) ? BANK_D : (c <= 3'h3) ? BANK_B : BANK_C;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hold a request until taken; returns on the taking edge, request still up
  task automatic issue(input logic w, input logic [ADDR_W-1:0] x, input logic [15:0] d,
                       input logic hit);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= x;
    req_wdata <= d;
    do begin @(negedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 400);
    chk(req_ready, 1, "request not taken");
    @(posedge clk_sys);
    exp_q.push_back('{w, hit, x, cyc});
  endtask
  task automatic idle;
    req_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_rsp;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin @(posedge clk_sys); n++; end
    chk(exp_q.size(), 0, "response missing");
  endtask

  // ----------------------------------------------------------------
  // Cycle count and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 40000) begin miscompares++; report_and_stop(); end
  end

  // ----------------------------------------------------------------
  // Pin and response monitor, sampled where outputs are settled
  // ----------------------------------------------------------------
  always @(negedge clk_sys) if (arst_n) begin
    if (!chip_select_n && !output_en_n) chk({write_en_n, data_pins_oe}, 2'b10, "rd pins");
    if (!chip_select_n && !write_en_n) chk(output_en_n, 1, "wr pins");
    if (!dev_reset_n) begin
      rlow++;
      since = 0;
    end else begin
      if (rlow > 0) chk(rlow >= RST_CYC, 1, "reset width");
      rlow = 0;
      since++;
    end
    if (!chip_select_n) chk(since >= RESET_TO_READ_CYC, 1, "read after reset");
    if (rsp_valid) begin
      if (exp_q.size() == 0) chk(1, 0, "stray response");
      else begin
        e = exp_q.pop_front();
        chk(rsp_bank, exp_bank(e.a[21:19]), "bank");
        if (!e.w) begin
          chk(rsp_rdata, exp_word(e.a), "read data");
          chk(addr_pins, e.a, "address");
          chk(cyc - e.t < ADDR_ACCESS_CYC, e.hit, "access time");
        end
      end
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    issue(0, 22'h000010, 0, 0);
    idle;
    for (int c = 0; c < 8; c++) issue(0, {3'(c), 19'h1a3c8}, 0, 0);
    for (int w = 0; w < 8; w++) issue(0, 22'h2abcd8 | 22'(w), 0, w != 0);
    issue(0, 22'h2abce0, 0, 0);
    idle;
    wait_rsp;
    // Erase in one bank, read another meanwhile
    issue(1, 22'h000100, 16'h0030, 0);
    issue(0, 22'h3c0040, 0, 0);
    idle;
    wait_rsp;
    @(negedge clk_sys);
    chk(dev_busy, 1, "busy");
    for (int n = 0; n < 400 && dev_busy !== 1'b0; n++) @(negedge clk_sys);
    chk(dev_busy, 0, "busy clear");
    @(posedge clk_sys);
    req_accel <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(accel_hv_en, 1, "accel on");
    @(posedge clk_sys);
    issue(1, 22'h000555, 16'h00a0, 0);
    issue(1, 22'h001234, 16'h5a5a, 0);
    idle;
    wait_rsp;
    req_accel <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(accel_hv_en, 0, "accel off");
    // Reset cuts an erase; busy must hold through recovery
    @(posedge clk_sys);
    issue(1, 22'h080000, 16'h0030, 0);
    idle;
    wait_rsp;
    req_reset <= 1'b1;
    for (int n = 0; n < 50 && dev_reset_n !== 1'b0; n++) @(negedge clk_sys);
    chk(dev_busy, 1, "busy in reset");
    @(posedge clk_sys);
    req_reset <= 1'b0;
    issue(0, 22'h080008, 0, 0);
    chk(ready_busy_n, 1, "ready after reset");
    idle;
    // The erase cut by the reset is issued again
    issue(1, 22'h080000, 16'h0030, 0);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      a = seed[21:0];
      issue(0, a, 16'(seed[31:16]), 0);
      if (seed[25]) issue(0, {a[21:3], seed[28:26]}, 0, 1);
      idle;
    end
    wait_rsp;
    report_and_stop();
  end
endmodule

`default_nettype wire
